// File: rtl/rtc_divider_chain.v
// real time clock: source select, prescalers, prescale timer, 32-bit count
// Summary of operation
// - the chain is clocked from an internal tick or an external pin selected by a control input.
// - a divide-by-32 and a divide-by-8 prescaler can each be switched in or bypassed.
// - the prescaler output drives a reloadable 16-bit prescale timer.
// - after it a 32-bit block of cascaded 10, 6, 6 and 10 bit reloadable timers follows.
// - the 32-bit count is read as a high word and a low word.
// - every stage counts up only.
// - each stage raises its own interrupt request on overflow.
// - all stage requests are merged into one shared request.
// - only the power reset clears the clock state; the lesser reset leaves it alone.
`timescale 1ns/1ps
`include "rtc_defs.vh"
module rtc_divider_chain #(
  parameter PT_W = 16,
  parameter W0   = 10,
  parameter W1   = 6,
  parameter W2   = 6,
  parameter W3   = 10
) (
  input  wire                    i_clk,
  input  wire                    i_reset,
  input  wire                    i_por,
  input  wire                    i_int_tick,
  input  wire                    i_ext_clk,
  input  wire                    i_src_sel,
  input  wire                    i_pre32_en,
  input  wire                    i_pre8_en,
  input  wire [PT_W-1:0]         i_pt_reload,
  input  wire [W0+W1+W2+W3-1:0]  i_cnt_reload,
  input  wire                    i_pt_load,
  input  wire                    i_cnt_load,
  input  wire [4:0]              i_irq_clr,
  output reg  [PT_W-1:0]         o_prescale_timer,
  output reg  [15:0]             o_count_high_word,
  output reg  [15:0]             o_count_low_word,
  output reg  [4:0]              o_irq_req,
  output reg                     o_node_req
);
  localparam CW = W0 + W1 + W2 + W3;

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser and source select
  reg        ext_s1_r;
  reg        ext_s2_r;
  reg        ext_s3_r;
  reg        tick_src;
  wire       ext_rise;
  // pin is asynchronous; the second and third flops feed the edge detector
  always @(posedge i_clk) begin
    if (i_por) begin
      ext_s1_r <= `RTC_SYNC_RESET;
      ext_s2_r <= `RTC_SYNC_RESET;
      ext_s3_r <= `RTC_SYNC_RESET;
    end else begin
      ext_s1_r <= i_ext_clk;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end
  assign ext_rise = ext_s2_r & ~ext_s3_r;
  always @* begin
    case (i_src_sel)
      `RTC_SEL_EXTERNAL: begin
        tick_src = ext_rise;
      end
      default: begin
        tick_src = i_int_tick;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // prescalers; lesser reset deliberately unused, state survives it
  reg  [4:0] pre32_r;
  reg  [4:0] pre32_nxt;
  reg  [2:0] pre8_r;
  reg  [2:0] pre8_nxt;
  wire       pre32_wrap;
  wire       pre8_wrap;
  wire       t32;
  wire       t8;
  assign pre32_wrap = (pre32_r == `RTC_PRE32_LAST);
  assign pre8_wrap  = (pre8_r == `RTC_PRE8_LAST);
  assign t32 = i_pre32_en ? (tick_src & pre32_wrap) : tick_src;
  assign t8  = i_pre8_en  ? (t32 & pre8_wrap) : t32;
  // a bypassed divider holds its phase rather than clearing it
  always @* begin
    pre32_nxt = pre32_r;
    pre8_nxt  = pre8_r;
    if (tick_src & i_pre32_en) begin
      pre32_nxt = pre32_r + `RTC_PRE32_STEP;
    end
    if (t32 & i_pre8_en) begin
      pre8_nxt = pre8_r + `RTC_PRE8_STEP;
    end
  end
  always @(posedge i_clk) begin
    if (i_por) begin
      pre32_r <= `RTC_PRE32_RESET;
      pre8_r  <= `RTC_PRE8_RESET;
    end else begin
      pre32_r <= pre32_nxt;
      pre8_r  <= pre8_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prescale timer and 32-bit count block
  localparam O1 = W0;
  localparam O2 = W0 + W1;
  localparam O3 = W0 + W1 + W2;
  wire [PT_W-1:0] pt_count;
  wire [CW-1:0]   cnt;
  wire [W0-1:0]   c0;
  wire [W1-1:0]   c1;
  wire [W2-1:0]   c2;
  wire [W3-1:0]   c3;
  wire [W0-1:0]   rl0;
  wire [W1-1:0]   rl1;
  wire [W2-1:0]   rl2;
  wire [W3-1:0]   rl3;
  wire [4:0]      carry;
  wire [4:0]      tick;
  // reload fields sit in stage order, lowest stage in the lowest bits
  assign rl0     = i_cnt_reload[O1-1:0];
  assign rl1     = i_cnt_reload[O2-1:O1];
  assign rl2     = i_cnt_reload[O3-1:O2];
  assign rl3     = i_cnt_reload[CW-1:O3];
  assign cnt     = {c3, c2, c1, c0};
  assign tick[0] = t8;
  genvar g;
  generate
    for (g = 1; g < 5; g = g + 1) begin : g_cascade
      assign tick[g] = carry[g-1];
    end
  endgenerate

  rtc_stage #(.W(PT_W)) u_pt (
    .i_clk    (i_clk),
    .i_por    (i_por),
    .i_tick   (tick[0]),
    .i_reload (i_pt_reload),
    .i_load   (i_pt_load),
    .o_count  (pt_count),
    .o_carry  (carry[0])
  );
  rtc_stage #(.W(W0)) u_s0 (
    .i_clk    (i_clk),
    .i_por    (i_por),
    .i_tick   (tick[1]),
    .i_reload (rl0),
    .i_load   (i_cnt_load),
    .o_count  (c0),
    .o_carry  (carry[1])
  );
  rtc_stage #(.W(W1)) u_s1 (
    .i_clk    (i_clk),
    .i_por    (i_por),
    .i_tick   (tick[2]),
    .i_reload (rl1),
    .i_load   (i_cnt_load),
    .o_count  (c1),
    .o_carry  (carry[2])
  );
  rtc_stage #(.W(W2)) u_s2 (
    .i_clk    (i_clk),
    .i_por    (i_por),
    .i_tick   (tick[3]),
    .i_reload (rl2),
    .i_load   (i_cnt_load),
    .o_count  (c2),
    .o_carry  (carry[3])
  );
  rtc_stage #(.W(W3)) u_s3 (
    .i_clk    (i_clk),
    .i_por    (i_por),
    .i_tick   (tick[4]),
    .i_reload (rl3),
    .i_load   (i_cnt_load),
    .o_count  (c3),
    .o_carry  (carry[4])
  );

  ////////////////////////////////////////////////////////////////////////
  // registered outputs and sticky requests; set wins over clear
  localparam NREQ = 5;
  wire [NREQ-1:0] irq_nxt;
  reg  [PT_W-1:0] pt_out_nxt;
  reg  [15:0]     high_nxt;
  reg  [15:0]     low_nxt;
  reg             node_nxt;
  // a carry in the clearing cycle keeps its request
  generate
    for (g = 0; g < NREQ; g = g + 1) begin : g_req
      assign irq_nxt[g] = carry[g] | (o_irq_req[g] & ~i_irq_clr[g]);
    end
  endgenerate
  always @* begin
    pt_out_nxt = pt_count;
    high_nxt   = cnt[CW-1:`RTC_LOW_BITS];
    low_nxt    = cnt[`RTC_LOW_BITS-1:0];
    node_nxt   = |irq_nxt;
  end
  always @(posedge i_clk) begin
    if (i_por) begin
      o_prescale_timer  <= `RTC_PT_RESET;
      o_count_high_word <= `RTC_WORD_RESET;
      o_count_low_word  <= `RTC_WORD_RESET;
      o_irq_req         <= `RTC_IRQ_RESET;
      o_node_req        <= `RTC_NODE_RESET;
    end else begin
      o_prescale_timer  <= pt_out_nxt;
      o_count_high_word <= high_nxt;
      o_count_low_word  <= low_nxt;
      o_irq_req         <= irq_nxt;
      o_node_req        <= node_nxt;
    end
  end
endmodule // rtc_divider_chain

// File: rtl/rtc_defs.vh
// constants for the real time clock divider chain
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH
`define RTC_PRE32_LAST   5'h1F
`define RTC_PRE8_LAST    3'h7
`define RTC_SEL_INTERNAL 1'b0
`define RTC_SEL_EXTERNAL 1'b1
`define RTC_LOW_BITS     16
`define RTC_PT_RESET     16'h0000
`define RTC_CNT_RESET    32'h0000_0000
`define RTC_ONE          1'b1
`define RTC_PRE32_RESET  5'h00
`define RTC_PRE8_RESET   3'h0
`define RTC_PRE32_STEP   5'h01
`define RTC_PRE8_STEP    3'h1
`define RTC_WORD_RESET   16'h0000
`define RTC_IRQ_RESET    5'h00
`define RTC_NODE_RESET   1'b0
`define RTC_SYNC_RESET   1'b0
`endif

// File: rtl/rtc_stage.v
// one reloadable up-counting divider stage
`timescale 1ns/1ps
module rtc_stage #(
  parameter W = 10
) (
  input  wire         i_clk,
  input  wire         i_por,
  input  wire         i_tick,
  input  wire [W-1:0] i_reload,
  input  wire         i_load,
  output wire [W-1:0] o_count,
  output wire         o_carry
);
  reg  [W-1:0] count_r;
  reg  [W-1:0] count_nxt;
  wire         full;

  assign full    = &count_r;
  // a load in the same cycle wins, so no carry leaks past it
  assign o_carry = i_tick & full & ~i_load;
  assign o_count = count_r;

  always @* begin
    count_nxt = count_r;
    if (i_load) begin
      count_nxt = i_reload;
    end else if (i_tick) begin
      if (full) begin
        count_nxt = i_reload;
      end else begin
        count_nxt = count_r + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge i_clk) begin
    if (i_por) begin
      count_r <= {W{1'b0}};
    end else begin
      count_r <= count_nxt;
    end
  end
endmodule // rtc_stage

// File: tb/rtc_checker.sv
// assertions on the rtc divider chain ports
`timescale 1ns/1ps
module rtc_checker (
  input wire        i_clk,
  input wire        i_por,
  input wire        i_int_tick,
  input wire        i_src_sel,
  input wire        i_pt_load,
  input wire        i_cnt_load,
  input wire [15:0] i_pt_reload,
  input wire [31:0] i_cnt_reload,
  input wire [4:0]  i_irq_clr,
  input wire [15:0] o_prescale_timer,
  input wire [15:0] o_count_high_word,
  input wire [15:0] o_count_low_word,
  input wire [4:0]  o_irq_req,
  input wire        o_node_req
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_por);
  ////////////////////////////////////////
  // three edges so a lagging output copy has caught up
  property p_por; disable iff (1'b0) i_por[*3] |-> o_irq_req == 0 && o_prescale_timer == 0; endproperty
  a_por: assert property (p_por) else $error("power reset");
  property p_sticky; i_irq_clr == 0 |=> (o_irq_req & $past(o_irq_req)) == $past(o_irq_req); endproperty
  a_sticky: assert property (p_sticky) else $error("request lost");
  property p_clear; i_irq_clr == 5'h1F && !i_int_tick && !i_src_sel |=> ##[0:1] o_irq_req == 0; endproperty
  a_clear: assert property (p_clear) else $error("clear");
  property p_node_set; $rose(|o_irq_req) |-> ##[0:1] o_node_req; endproperty
  a_node_set: assert property (p_node_set) else $error("node set");
  property p_node_clr; (o_irq_req == 0)[*2] |-> !o_node_req; endproperty
  a_node_clr: assert property (p_node_clr) else $error("node clear");
  property p_pt_load; i_pt_load |=> ##1 o_prescale_timer == $past(i_pt_reload, 2); endproperty
  a_pt_load: assert property (p_pt_load) else $error("timer load");
  property p_cnt_load;
    i_cnt_load |=> ##1 {o_count_high_word, o_count_low_word} == $past(i_cnt_reload, 2);
  endproperty
  a_cnt_load: assert property (p_cnt_load) else $error("count load");
  property p_hold; (!i_int_tick && !i_pt_load && !i_src_sel)[*2] |=> $stable(o_prescale_timer); endproperty
  a_hold: assert property (p_hold) else $error("moved idle");
endmodule // rtc_checker
bind rtc_divider_chain rtc_checker u_rtc_checker (.*);

// File: tb/tb.sv
// self-checking bench for the rtc divider chain
`timescale 1ns/1ps
module tb;
  reg         i_clk = 0, i_reset = 1, i_por = 1, i_int_tick = 0, i_ext_clk = 0;
  reg         i_src_sel = 0, i_pre32_en = 0, i_pre8_en = 0, i_pt_load = 0, i_cnt_load = 0;
  reg  [15:0] i_pt_reload = 16'hFFFF;
  reg  [31:0] i_cnt_reload = 32'hFFFF_FFFF;
  reg  [4:0]  i_irq_clr = 5'h00;
  wire [15:0] o_prescale_timer, o_count_high_word, o_count_low_word;
  wire [4:0]  o_irq_req;
  wire        o_node_req;
  integer     miscompares = 0, comparisons = 0;
  rtc_divider_chain u_rtc_divider_chain (.*);
  always #2.5 i_clk = ~i_clk;
  ////////////////////////////////////////
  task step(input integer n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input integer n);
    i_int_tick = 1;
    step(n);
    i_int_tick = 0;
  endtask
  task load;
    {i_pt_load, i_cnt_load} = 2'h3;
    step(1);
    {i_pt_load, i_cnt_load} = 2'h0;
  endtask
  // every stage full, so one tick ripples through all of them
  task t_wrap;
    load;
    tick(1);
    step(2);
    chk(o_irq_req, 5'h1F);
    chk(o_node_req, 1'b1);
    chk({o_count_high_word, o_count_low_word}, 32'hFFFF_FFFF);
  endtask
  task t_keep;
    i_reset = 1;
    step(3);
    i_reset = 0;
    chk(o_irq_req, 5'h1F);
    i_irq_clr = 5'h1F;
    step(1);
    i_irq_clr = 5'h00;
    step(2);
    chk({o_node_req, o_irq_req}, 6'h00);
  endtask
  // tick counts chosen so any prescaler phase gives the same result
  task t_count;
    i_pt_reload = 16'h0000;
    load;
    tick(3);
    step(2);
    chk(o_prescale_timer, 16'h0003);
    i_pre8_en = 1;
    tick(8);
    step(2);
    chk(o_prescale_timer, 16'h0004);
    {i_pre8_en, i_pre32_en} = 2'h1;
    tick(64);
    step(2);
    chk(o_prescale_timer, 16'h0006);
    {i_pre32_en, i_src_sel} = 2'h1;
    repeat (3) begin
      i_ext_clk = 1;
      step(3);
      i_ext_clk = 0;
      step(3);
    end
    step(3);
    chk(o_prescale_timer, 16'h0009);
    i_src_sel = 0;
  endtask
  task print_verdict;
    if (miscompares == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    step(4);
    {i_por, i_reset} = 2'h0;
    t_wrap;
    t_keep;
    t_count;
    print_verdict;
  end
  initial begin
    #5000;
    miscompares = miscompares + 1;
    print_verdict;
  end
endmodule // tb
